// ==== core/wait_state_generator.sv ====
// Software-programmable wait-state generator for the external bus.
// What this block does
// - Stretch external cycles up to fourteen waits.
// - Withheld ready keeps extending the cycle.
// - All-zero counts gate off counter clocking.
// - Fifteen low bits hold five counts.
// - Multiplier bit doubles counts, reset clear.
// - Seven waits on every access after reset.
// - Bit 15 selects program range mapping.
// - Bits 14..12 set I/O count.
// - Bits 11..9 set upper data count.
// - Bits 8..6 set lower data count.
// - Bits 5..3 upper program page, range-select 0.
// - Bits 2..0 lower page or whole space.
// - Config bits 15..1 read zero, ignore writes.
`timescale 1ns/100ps
module wait_state_generator
    import wait_state_pkg::*;
#(
    parameter int PROG_ADDR_W = 20
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic regSel,
    input wire logic regWrite,
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    input wire logic accessStart,
    input wire logic [1:0] accessSpace,
    input wire logic [PROG_ADDR_W-1:0] accessAddr,
    input wire logic readyIn,
    output logic accessDone,
    output logic accessBusy,
    output logic wsClkEn
);

    // ------------------------------------------------------------
    // Reset release and ready synchroniser
    // ------------------------------------------------------------
    logic rstMeta_r;
    logic rstSync_r;
    logic readyMeta_r;
    logic readySync_r;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end
        else
        begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    always_ff @(posedge ref_clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            readyMeta_r <= 1'b0;
            readySync_r <= 1'b0;
        end
        else
        begin
            readyMeta_r <= readyIn;
            readySync_r <= readyMeta_r;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] countReg_r;
    logic [15:0] configReg_r;
    logic [15:0] regRdata_r;
    logic countHit;
    logic configHit;

    assign countHit = regSel && (regAddr == WAIT_COUNT_OFS);
    assign configHit = regSel && (regAddr == WAIT_CONFIG_OFS);

    always_ff @(posedge ref_clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            countReg_r <= WAIT_COUNT_RST;
        end
        else if (countHit && regWrite)
        begin
            countReg_r <= regWdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            configReg_r <= WAIT_CONFIG_RST;
        end
        else if (configHit && regWrite)
        begin
            configReg_r <= {15'h0000, regWdata[MULT_BIT]};
        end
    end

    // Unmapped addresses read as zero so software probing sees a defined value.
    always_ff @(posedge ref_clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            regRdata_r <= 16'h0000;
        end
        else if (regSel && !regWrite)
        begin
            regRdata_r <= countHit ? countReg_r : (configHit ? configReg_r : 16'h0000);
        end
    end

    assign regRdata = regRdata_r;

    // ------------------------------------------------------------
    // Count selection
    // ------------------------------------------------------------
    function automatic logic [2:0] field(input logic [15:0] reg_v, input int lsb);
        field = reg_v[lsb +: FIELD_W];
    endfunction : field

    function automatic logic [2:0] selectBase(input logic [15:0] reg_v, input logic [1:0] space,
                                              input logic upper);
        logic [2:0] base;
        base = field(reg_v, IO_LSB);
        if (space == SPACE_DATA)
        begin
            base = upper ? field(reg_v, DATA_HI_LSB) : field(reg_v, DATA_LO_LSB);
        end
        else if (space == SPACE_PROG)
        begin
            base = (upper && !reg_v[RANGE_SEL_BIT]) ? field(reg_v, PROG_HI_LSB) : field(reg_v, PROG_LO_LSB);
        end
        selectBase = base;
    endfunction : selectBase

    logic [2:0] baseCount;
    logic [3:0] scaledCount;
    logic allZero;

    assign baseCount = selectBase(countReg_r, accessSpace, accessAddr[SPLIT_BIT]);

    assign scaledCount = configReg_r[MULT_BIT] ? {baseCount, 1'b0} : {1'b0, baseCount};

    // all ranges zero means gate off
    assign allZero = (countReg_r[14:0] == 15'h0000);

    always_ff @(posedge ref_clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            wsClkEn <= 1'b1;
        end
        else
        begin
            wsClkEn <= !allZero;
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    wait_if ifc ();

    // With the counter gated off every access costs zero waits; ready still applies.
    assign ifc.start = accessStart;
    assign ifc.count = wsClkEn ? scaledCount : 4'h0;
    assign ifc.readySync = readySync_r;
    assign accessDone = ifc.done;
    assign accessBusy = ifc.busy;

    wait_counter counter_i (
        .ref_clk(ref_clk),
        .rstSync(rstSync_r),
        .ifc(ifc)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_config_reserved: assert property (@(posedge ref_clk) disable iff (!rstSync_r)
        configReg_r[15:1] == 15'h0000)
        else $error("Reserved config bits are not zero.");

    a_reset_seven: assert property (@(posedge ref_clk)
        (rstSync_r && !$past(rstSync_r)) |-> (countReg_r == WAIT_COUNT_RST && configReg_r == WAIT_CONFIG_RST))
        else $error("Reset counts are not seven waits.");

    a_read_count: assert property (@(posedge ref_clk) disable iff (!rstSync_r)
        (countHit && !regWrite) |=> regRdata_r == $past(countReg_r))
        else $error("Wait count register read back wrong.");

    a_clock_gate: assert property (@(posedge ref_clk) disable iff (!rstSync_r)
        $past(allZero) |-> !wsClkEn)
        else $error("Counter clocking not gated with all-zero counts.");

    a_io_count: assert property (@(posedge ref_clk) disable iff (!rstSync_r)
        (wsClkEn && accessSpace == SPACE_IO) |-> ifc.count == ({1'b0, countReg_r[14:12]} << configReg_r[0]))
        else $error("I/O access took wrong count.");

    a_data_upper: assert property (@(posedge ref_clk) disable iff (!rstSync_r)
        (wsClkEn && accessSpace == SPACE_DATA && accessAddr[15]) |->
            ifc.count == ({1'b0, countReg_r[11:9]} << configReg_r[0]))
        else $error("Upper data access took wrong count.");

    a_data_lower: assert property (@(posedge ref_clk) disable iff (!rstSync_r)
        (wsClkEn && accessSpace == SPACE_DATA && !accessAddr[15]) |->
            ifc.count == ({1'b0, countReg_r[8:6]} << configReg_r[0]))
        else $error("Lower data access took wrong count.");

    a_prog_upper: assert property (@(posedge ref_clk) disable iff (!rstSync_r)
        (wsClkEn && accessSpace == SPACE_PROG && accessAddr[15] && !countReg_r[15]) |->
            ifc.count == ({1'b0, countReg_r[5:3]} << configReg_r[0]))
        else $error("Upper program access took wrong count.");

    a_prog_lower: assert property (@(posedge ref_clk) disable iff (!rstSync_r)
        (wsClkEn && accessSpace == SPACE_PROG && (!accessAddr[15] || countReg_r[15])) |->
            ifc.count == ({1'b0, countReg_r[2:0]} << configReg_r[0]))
        else $error("Lower or extended program access took wrong count.");

endmodule : wait_state_generator

// ==== core/wait_state_pkg.sv ====
// Package with register map, field layout and reset values of the wait-state generator.
package wait_state_pkg;

    // ------------------------------------------------------------
    // Register offsets in the memory-mapped register space
    // ------------------------------------------------------------
    localparam logic [15:0] WAIT_COUNT_OFS = 16'h0028;
    localparam logic [15:0] WAIT_CONFIG_OFS = 16'h002B;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] WAIT_COUNT_RST = 16'h7FFF;
    localparam logic [15:0] WAIT_CONFIG_RST = 16'h0000;

    // ------------------------------------------------------------
    // Field positions of the wait count and config registers and the access address split
    // ------------------------------------------------------------
    localparam int RANGE_SEL_BIT = 15;
    localparam int IO_LSB = 12;
    localparam int DATA_HI_LSB = 9;
    localparam int DATA_LO_LSB = 6;
    localparam int PROG_HI_LSB = 3;
    localparam int PROG_LO_LSB = 0;
    localparam int FIELD_W = 3;
    localparam int MULT_BIT = 0;
    localparam int SPLIT_BIT = 15;

    // ------------------------------------------------------------
    // Limits and encodings
    // ------------------------------------------------------------
    localparam logic [3:0] MAX_WAITS = 4'hE;

    typedef enum logic [1:0] {
        SPACE_PROG = 2'b00,
        SPACE_DATA = 2'b01,
        SPACE_IO = 2'b10
    } space_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_COUNT = 2'b01
    } wait_state_e;

endpackage : wait_state_pkg

// ==== core/wait_if.sv ====
// Interface between the register side and the wait counter.
`timescale 1ns/100ps
interface wait_if;
    logic start;
    logic [3:0] count;
    logic readySync;
    logic done;
    logic busy;

    modport ctrl (output start, output count, output readySync, input done, input busy);
    modport counter (input start, input count, input readySync, output done, output busy);
endinterface : wait_if

// ==== core/wait_counter.sv ====
// Wait counter that stretches one external bus cycle.
`timescale 1ns/100ps
module wait_counter
    import wait_state_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstSync,
    wait_if.counter ifc
);

    wait_state_e state_r;
    logic [3:0] remain_r;
    logic done_r;
    logic busy_r;

    // Busy is its own flop so the top-level output comes straight from a register.
    assign ifc.done = done_r;
    assign ifc.busy = busy_r;

    always_ff @(posedge ref_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            state_r <= ST_IDLE;
            remain_r <= 4'h0;
            done_r <= 1'b0;
            busy_r <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            unique case (state_r)
                ST_IDLE:
                begin
                    if (ifc.start)
                    begin
                        remain_r <= ifc.count;
                        state_r <= ST_COUNT;
                        busy_r <= 1'b1;
                    end
                end
                ST_COUNT:
                begin
                    if (remain_r != 4'h0)
                    begin
                        remain_r <= remain_r - 4'h1;
                    end
                    else if (ifc.readySync)
                    begin
                        done_r <= 1'b1;
                        state_r <= ST_IDLE;
                        busy_r <= 1'b0;
                    end
                end
                default:
                begin
                    state_r <= ST_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_zero_start;
        ifc.start && !ifc.busy && ifc.count == 4'h0 ##1 ifc.readySync;
    endsequence

    a_zero_wait_done: assert property (@(posedge ref_clk) disable iff (!rstSync)
        s_zero_start |=> done_r)
        else $error("Zero-wait access did not end two cycles after start.");

    a_ready_hold: assert property (@(posedge ref_clk) disable iff (!rstSync)
        (state_r == ST_COUNT && remain_r == 4'h0 && !ifc.readySync) |=> (state_r == ST_COUNT && !done_r))
        else $error("Cycle ended while ready was withheld.");

    a_count_bound: assert property (@(posedge ref_clk) disable iff (!rstSync)
        remain_r <= MAX_WAITS)
        else $error("Wait count exceeds fourteen.");

    a_done_cause: assert property (@(posedge ref_clk) disable iff (!rstSync)
        done_r |-> ($past(remain_r) == 4'h0 && $past(ifc.readySync)))
        else $error("Done without elapsed count and ready.");

endmodule : wait_counter

// ==== tb/ext_device_model.sv ====
// Model of an external memory or I/O device that drives the ready line.
`timescale 1ns/100ps
module ext_device_model
(
    input wire logic ref_clk,
    input wire logic accessStart,
    input wire logic accessBusy,
    input wire logic [7:0] holdCycles,
    output logic readyIn
);
    logic [7:0] holdLeft_r = 8'h00;

    // ------------------------------------------------------------
    // Ready withholding
    // ------------------------------------------------------------
    // slow device withholds ready
    always_ff @(posedge ref_clk)
    begin
        if (accessStart && !accessBusy)
        begin
            holdLeft_r <= holdCycles;
        end
        else if (holdLeft_r != 8'h00)
        begin
            holdLeft_r <= holdLeft_r - 8'h01;
        end
    end

    // Ready is driven high once no hold cycles remain, so an idle device leaves it high.
    assign readyIn = (holdLeft_r == 8'h00);
endmodule : ext_device_model

// ==== tb/tb.sv ====
// Testbench for the wait-state generator.
`timescale 1ns/100ps
module tb;
    import wait_state_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic regSel = 1'b0;
    logic regWrite = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [15:0] regWdata = 16'h0000;
    logic [15:0] regRdata;
    logic accessStart = 1'b0;
    logic [1:0] accessSpace = 2'h0;
    logic [19:0] accessAddr = 20'h00000;
    logic [7:0] holdCycles = 8'h00;
    logic readyIn, accessDone, accessBusy, wsClkEn;
    logic mult = 1'b0;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int waited;

    wait_state_generator i_dut (.ref_clk, .rst_b, .regSel, .regWrite, .regAddr, .regWdata, .regRdata,
        .accessStart, .accessSpace, .accessAddr, .readyIn, .accessDone, .accessBusy, .wsClkEn);
    ext_device_model i_dev (.ref_clk, .accessStart, .accessBusy, .holdCycles, .readyIn);

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task reg_wr(input logic [15:0] addr, input logic [15:0] data);
        regSel = 1'b1;
        regWrite = 1'b1;
        regAddr = addr;
        regWdata = data;
        @(negedge ref_clk);
        regSel = 1'b0;
        @(negedge ref_clk);
    endtask : reg_wr

    task reg_rd(input logic [15:0] addr, input logic [15:0] exp);
        regSel = 1'b1;
        regWrite = 1'b0;
        regAddr = addr;
        @(negedge ref_clk);
        regSel = 1'b0;
        check("regRdata", regRdata, exp);
        @(negedge ref_clk);
    endtask : reg_rd

    // Runs one access and returns the cycles from the taking edge to the end pulse.
    task run_acc(input logic [1:0] space, input logic [19:0] addr);
        accessStart = 1'b1;
        accessSpace = space;
        accessAddr = addr;
        @(negedge ref_clk);
        accessStart = 1'b0;
        waited = 0;
        check("accessBusy", 16'(accessBusy), 16'h0001);
        while (accessDone !== 1'b1 && waited < 200)
        begin
            @(negedge ref_clk);
            waited++;
        end
        check("accessBusy", 16'(accessBusy), 16'h0000);
    endtask : run_acc

    task acc(input logic [1:0] space, input logic [19:0] addr, input int base);
        run_acc(space, addr);
        check("waitCycles", 16'(waited), 16'((mult ? 2 * base : base) + 1));
    endtask : acc

    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end

    // Ceiling well above the fewer than two hundred cycles the tests need.
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge ref_clk);
        reg_rd(WAIT_COUNT_OFS, 16'h7FFF);
        reg_rd(WAIT_CONFIG_OFS, 16'h0000);
        reg_rd(16'h0029, 16'h0000);
        acc(2'h0, 20'h00000, 7);
        acc(2'h1, 20'h08000, 7);
        acc(2'h2, 20'h0FFFF, 7);
        $display("test reset done");
        reg_wr(WAIT_CONFIG_OFS, 16'hFFFF);
        reg_rd(WAIT_CONFIG_OFS, 16'h0001);
        mult = 1'b1;
        acc(2'h1, 20'h00000, 7);
        reg_wr(WAIT_CONFIG_OFS, 16'h0000);
        mult = 1'b0;
        $display("test multiplier done");
        reg_wr(WAIT_COUNT_OFS, 16'h14E5);
        reg_rd(WAIT_COUNT_OFS, 16'h14E5);
        acc(2'h2, 20'h00000, 1);
        acc(2'h3, 20'h0FFFF, 1);
        acc(2'h1, 20'h08000, 2);
        acc(2'h1, 20'h07FFF, 3);
        acc(2'h0, 20'h38000, 4);
        acc(2'h0, 20'h37FFF, 5);
        reg_wr(WAIT_COUNT_OFS, 16'h94E5);
        acc(2'h0, 20'h38000, 5);
        acc(2'h0, 20'hF0000, 5);
        reg_wr(WAIT_CONFIG_OFS, 16'h0001);
        mult = 1'b1;
        acc(2'h1, 20'h07FFF, 3);
        acc(2'h0, 20'h08000, 5);
        reg_wr(WAIT_CONFIG_OFS, 16'h0000);
        mult = 1'b0;
        $display("test fields done");
        reg_wr(WAIT_COUNT_OFS, 16'h0000);
        @(negedge ref_clk);
        check("wsClkEn", 16'(wsClkEn), 16'h0000);
        acc(2'h1, 20'h00000, 0);
        reg_wr(WAIT_COUNT_OFS, 16'h0080);
        @(negedge ref_clk);
        check("wsClkEn", 16'(wsClkEn), 16'h0001);
        holdCycles = 8'd20;
        run_acc(2'h1, 20'h00000);
        check("readyHeld", 16'(holdCycles + 8'd3), 16'(waited));
        holdCycles = 8'd0;
        $display("test gating and ready done");
        wrap_up();
    end
endmodule : tb
